// *** pbcs_clock_select.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbcs_clock_select
  import pbcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        bus_clock_input,
  input  wire logic        gen_clock,
  input  wire logic        feedback_clock_in,
  input  wire pbcs_strap_t strap_pins,
  output logic [6:0]       bus_clock_out,
  output logic             gen_enable,
  output logic             auto_detect_en,
  output pbcs_freq_t       freq_sel
);

  // pin synchronisers; stage one is read only by stage two
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        pin_d_r;
  logic [2:0]  prime_r;
  pbcs_strap_t strap_s1_r;
  pbcs_strap_t strap_s2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r   <= 1'b0;
      pin_s2_r   <= 1'b0;
      pin_d_r    <= 1'b0;
      prime_r    <= '0;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      pin_s1_r   <= bus_clock_input;
      pin_s2_r   <= pin_s1_r;
      pin_d_r    <= pin_s2_r;
      prime_r    <= {prime_r[1:0], 1'b1};
      strap_s1_r <= strap_pins;
      strap_s2_r <= strap_s1_r;
    end
  end

  // rising edge at the sampled rate; a fast clock aliases but still toggles.
  // blind until pin_d_r holds a real sample, else a pin strapped high would
  // count one false rise after every reset
  logic rise_w;
  assign rise_w = prime_r[2] & pin_s2_r & ~pin_d_r;

  // rising edge counter, saturates at the limit
  logic [3:0] edge_cnt_r;
  logic [3:0] edge_cnt_nxt;

  always_comb begin
    edge_cnt_nxt = edge_cnt_r;
    if (rise_w && edge_cnt_r != PBCS_EDGE_LIMIT) begin
      edge_cnt_nxt = edge_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_cnt_r <= '0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
    end
  end

  // clock source mode; external is left only by chip reset
  pbcs_mode_t mode_r;
  pbcs_mode_t mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PBCS_MODE_INT: begin
        if (edge_cnt_nxt == PBCS_EDGE_LIMIT) begin
          mode_nxt = PBCS_MODE_EXT;
        end
      end
      PBCS_MODE_EXT: begin
        mode_nxt = PBCS_MODE_EXT;
      end
      default: begin
        mode_nxt = PBCS_MODE_EXT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= PBCS_MODE_INT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  logic ext_w;
  assign ext_w = (mode_r == PBCS_MODE_EXT);

  // internal generator and auto detection follow the mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_enable     <= 1'b1;
      auto_detect_en <= 1'b1;
    end else begin
      gen_enable     <= (mode_nxt == PBCS_MODE_INT);
      auto_detect_en <= (mode_nxt == PBCS_MODE_INT);
    end
  end

  // frequency decode from the synchronised straps
  pbcs_freq_t freq_nxt;

  always_comb begin
    freq_nxt = PBCS_F_PCI33;
    if (strap_s2_r.cap == PBCS_CAP_GND) begin
      if (!pin_s2_r) begin
        freq_nxt = strap_s2_r.sel_up ? PBCS_F_PCI25 : PBCS_F_PCI33;
      end else begin
        freq_nxt = strap_s2_r.sel_up ? PBCS_F_PCI50 : PBCS_F_PCI66;
      end
    end else if (strap_s2_r.cap == PBCS_CAP_RES) begin
      freq_nxt = strap_s2_r.sel_up ? PBCS_F_X50 : PBCS_F_X66;
    end else begin
      freq_nxt = strap_s2_r.sel_up ? PBCS_F_X100 : PBCS_F_X133;
    end
    // reverse downstream port cannot run above 66
    if (strap_s2_r.reverse &&
        (freq_nxt == PBCS_F_X100 || freq_nxt == PBCS_F_X133)) begin
      freq_nxt = PBCS_F_X66;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_sel <= PBCS_F_PCI33;
    end else begin
      freq_sel <= freq_nxt;
    end
  end

  logic [7:0] mhz_w;

  always_comb begin
    mhz_w = PBCS_MHZ_33;
    unique case (freq_sel)
      PBCS_F_PCI25: mhz_w = PBCS_MHZ_25;
      PBCS_F_PCI33: mhz_w = PBCS_MHZ_33;
      PBCS_F_PCI50: mhz_w = PBCS_MHZ_50;
      PBCS_F_PCI66: mhz_w = PBCS_MHZ_66;
      PBCS_F_X50:   mhz_w = PBCS_MHZ_50;
      PBCS_F_X66:   mhz_w = PBCS_MHZ_66;
      PBCS_F_X100:  mhz_w = PBCS_MHZ_100;
      PBCS_F_X133:  mhz_w = PBCS_MHZ_133;
      default:      mhz_w = PBCS_MHZ_33;
    endcase
  end

  // apb slave, zero wait states
  logic        wr_w;
  logic        rd_setup_w;
  logic        mapped_w;
  logic [6:0]  clk_en_r;
  assign wr_w       = psel & penable & pwrite;
  assign rd_setup_w = psel & ~penable & ~pwrite;
  assign mapped_w   = (paddr == PBCS_CTRL_OFS) || (paddr == PBCS_STATUS_OFS) ||
                      (paddr == PBCS_FREQ_OFS);
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~mapped_w;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_en_r <= PBCS_CLK_EN_RST;
    end else if (wr_w && paddr == PBCS_CTRL_OFS) begin
      clk_en_r <= pwdata[PBCS_NUM_OUTS-1:0];
    end
  end

  logic         fb_alive_r;
  pbcs_status_t status_w;
  assign status_w = '{mhz: mhz_w, freq: freq_sel, edges: edge_cnt_r, spare: 1'b0,
                      fb_alive: fb_alive_r, gen_en: gen_enable, ext: ext_w};

  // read data captured in setup so it comes from a flop in access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (rd_setup_w) begin
      unique case (paddr)
        PBCS_CTRL_OFS:   prdata <= {25'h0, clk_en_r};
        PBCS_STATUS_OFS: prdata <= {8'h0, status_w};
        PBCS_FREQ_OFS:   prdata <= {24'h0, mhz_w};
        default:         prdata <= '0;
      endcase
    end
  end

  // feedback domain: enables cross bit by bit, they are quasi-static
  logic [6:0] en_fb_s1_r;
  logic [6:0] en_fb_s2_r;
  logic [3:0] fb_div_r;
  logic       fb_tgl_r;

  always_ff @(posedge feedback_clock_in or negedge arst_n) begin
    if (!arst_n) begin
      en_fb_s1_r <= '0;
      en_fb_s2_r <= '0;
      fb_div_r   <= '0;
      fb_tgl_r   <= 1'b0;
    end else begin
      en_fb_s1_r <= clk_en_r;
      en_fb_s2_r <= en_fb_s1_r;
      fb_div_r   <= fb_div_r + 4'h1;
      if (fb_div_r == PBCS_FB_DIV_MAX) begin
        fb_tgl_r <= ~fb_tgl_r;
      end
    end
  end

  // clock mux and gating; mux switch can glitch once, only at mode change
  logic src_clk_w;
  logic ext_fb_s1_r;
  logic ext_fb_s2_r;

  always_ff @(posedge feedback_clock_in or negedge arst_n) begin
    if (!arst_n) begin
      ext_fb_s1_r <= 1'b0;
      ext_fb_s2_r <= 1'b0;
    end else begin
      ext_fb_s1_r <= ext_w;
      ext_fb_s2_r <= ext_fb_s1_r;
    end
  end

  assign src_clk_w     = ext_fb_s2_r ? bus_clock_input : gen_clock;
  assign bus_clock_out = {PBCS_NUM_OUTS{src_clk_w}} & en_fb_s2_r;

  // feedback liveness back in clk domain through a toggle crossing
  logic       tgl_s1_r;
  logic       tgl_s2_r;
  logic       tgl_d_r;
  logic [7:0] fb_wait_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1_r   <= 1'b0;
      tgl_s2_r   <= 1'b0;
      tgl_d_r    <= 1'b0;
      fb_wait_r  <= '0;
      fb_alive_r <= 1'b0;
    end else begin
      tgl_s1_r <= fb_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r  <= tgl_s2_r;
      if (tgl_s2_r != tgl_d_r) begin
        fb_wait_r  <= '0;
        fb_alive_r <= 1'b1;
      end else if (fb_wait_r == PBCS_FB_TIMEOUT_CYC) begin
        fb_alive_r <= 1'b0;
      end else begin
        fb_wait_r <= fb_wait_r + 8'h1;
      end
    end
  end

  // checks
  ext_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    ext_w |=> ext_w) else $error("external mode was left without reset");

  edge_switch_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rise_w && edge_cnt_r == PBCS_EDGE_LIMIT - 4'h1) |=> ext_w)
    else $error("fifteenth edge did not force external mode");

  no_early_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ext_w) |-> $past(rise_w) && $past(edge_cnt_r) == PBCS_EDGE_LIMIT - 4'h1)
    else $error("external mode entered before fifteen edges");

  edge_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rise_w && edge_cnt_r < PBCS_EDGE_LIMIT) |=> edge_cnt_r == $past(edge_cnt_r) + 4'h1)
    else $error("rising edge on combined pin not counted");

  gen_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    ext_w |-> ##1 (!gen_enable && !auto_detect_en)[*2])
    else $error("internal generator still on in external mode");

  pci25_a: assert property (@(posedge clk) disable iff (!arst_n)
    (strap_s2_r.cap == PBCS_CAP_GND && !pin_s2_r && strap_s2_r.sel_up)
    |=> freq_sel == PBCS_F_PCI25) else $error("pci 25 not selected");

  x133_a: assert property (@(posedge clk) disable iff (!arst_n)
    (strap_s2_r.cap == PBCS_CAP_HIGH && !strap_s2_r.sel_up && !strap_s2_r.reverse)
    |=> freq_sel == PBCS_F_X133) else $error("extended 133 not selected");

  rev_clamp_a: assert property (@(posedge clk) disable iff (!arst_n)
    strap_s2_r.reverse |=> (mhz_w <= PBCS_MHZ_66))
    else $error("reverse port above 66");

  en_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_w && paddr == PBCS_CTRL_OFS) |=> clk_en_r == $past(pwdata[6:0]))
    else $error("clock enable write lost");

  rd_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_setup_w && paddr == PBCS_CTRL_OFS) |=> prdata == {25'h0, $past(clk_en_r)})
    else $error("enable readback wrong");

  gen_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!ext_w && edge_cnt_nxt != PBCS_EDGE_LIMIT) |=> (gen_enable && auto_detect_en))
    else $error("internal generator off in internal mode");

  pci66_a: assert property (@(posedge clk) disable iff (!arst_n)
    (strap_s2_r.cap == PBCS_CAP_GND && pin_s2_r && !strap_s2_r.sel_up)
    |=> freq_sel == PBCS_F_PCI66) else $error("pci 66 not selected");

  x50_a: assert property (@(posedge clk) disable iff (!arst_n)
    (strap_s2_r.cap == PBCS_CAP_RES && strap_s2_r.sel_up)
    |=> freq_sel == PBCS_F_X50) else $error("extended 50 not selected");

  out_gate_a: assert property (@(posedge feedback_clock_in) disable iff (!arst_n)
    !en_fb_s2_r[0] |-> !bus_clock_out[0]) else $error("disabled output toggles");

endmodule : pbcs_clock_select
`default_nettype wire

// *** pbcs_pkg.sv ***
`default_nettype none
package pbcs_pkg;

  // register map, byte addresses on the apb slave
  localparam logic [11:0] PBCS_CTRL_OFS   = 12'h000;
  localparam logic [11:0] PBCS_STATUS_OFS = 12'h004;
  localparam logic [11:0] PBCS_FREQ_OFS   = 12'h008;

  // clock output enables, one per output
  localparam int          PBCS_NUM_OUTS   = 7;
  localparam logic [6:0]  PBCS_CLK_EN_RST = 7'h7f;

  // status register field positions
  localparam int PBCS_ST_EXT_BIT   = 0;
  localparam int PBCS_ST_GEN_BIT   = 1;
  localparam int PBCS_ST_FB_BIT    = 2;
  localparam int PBCS_ST_CNT_LSB   = 4;
  localparam int PBCS_ST_FREQ_LSB  = 8;
  localparam int PBCS_ST_MHZ_LSB   = 16;

  // rising edges on the combined pin that force external mode
  localparam logic [3:0]  PBCS_EDGE_LIMIT = 4'hf;

  // feedback liveness timeout, time in ns and derived clk cycles
  localparam int          PBCS_CLK_PERIOD_NS  = 40;
  localparam int          PBCS_FB_TIMEOUT_NS  = 2560;
  localparam logic [7:0]  PBCS_FB_TIMEOUT_CYC =
    8'(PBCS_FB_TIMEOUT_NS / PBCS_CLK_PERIOD_NS);
  localparam logic [3:0]  PBCS_FB_DIV_MAX = 4'hf;

  // capability strap levels as delivered by the pad detector
  localparam logic [1:0]  PBCS_CAP_GND  = 2'h0;
  localparam logic [1:0]  PBCS_CAP_RES  = 2'h1;
  localparam logic [1:0]  PBCS_CAP_HIGH = 2'h2;

  // output frequencies in mhz
  localparam logic [7:0] PBCS_MHZ_25  = 8'h19;
  localparam logic [7:0] PBCS_MHZ_33  = 8'h21;
  localparam logic [7:0] PBCS_MHZ_50  = 8'h32;
  localparam logic [7:0] PBCS_MHZ_66  = 8'h42;
  localparam logic [7:0] PBCS_MHZ_100 = 8'h64;
  localparam logic [7:0] PBCS_MHZ_133 = 8'h85;

  typedef enum logic [7:0] {
    PBCS_F_PCI25  = 8'h01,
    PBCS_F_PCI33  = 8'h02,
    PBCS_F_PCI50  = 8'h04,
    PBCS_F_PCI66  = 8'h08,
    PBCS_F_X50    = 8'h10,
    PBCS_F_X66    = 8'h20,
    PBCS_F_X100   = 8'h40,
    PBCS_F_X133   = 8'h80
  } pbcs_freq_t;

  typedef enum logic [1:0] {
    PBCS_MODE_INT = 2'h1,
    PBCS_MODE_EXT = 2'h2
  } pbcs_mode_t;

  typedef struct packed {
    logic       reverse;
    logic       sel_up;
    logic [1:0] cap;
  } pbcs_strap_t;

  typedef struct packed {
    logic [7:0] mhz;
    logic [7:0] freq;
    logic [3:0] edges;
    logic       spare;
    logic       fb_alive;
    logic       gen_en;
    logic       ext;
  } pbcs_status_t;

endpackage : pbcs_pkg
`default_nettype wire

// *** pbcs_board_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbcs_board_model (
  output logic gen_clock,
  output logic feedback_clock_in,
  output logic ref_clock_pos,
  output logic ref_clock_neg
);
  // serial reference runs from time zero, long before any reset release;
  // offset so that its edges never share a time step with clk
  initial begin
    ref_clock_pos = 1'b0;
    #2;
    forever #5 ref_clock_pos = ~ref_clock_pos;
  end
  assign ref_clock_neg = ~ref_clock_pos;
  // generator runs free at 10 ns, with no offset, so its edges share time steps with clk
  initial gen_clock = 1'b0;
  always #5 gen_clock = ~gen_clock;
  // stands in for the looped-back output; it must run free, because the
  // outputs stay gated until this domain has seen edges
  initial begin
    feedback_clock_in = 1'b0;
    #3;
    forever #32 feedback_clock_in = ~feedback_clock_in;
  end
endmodule : pbcs_board_model
`default_nettype wire

// *** pbcs_clock_select_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module pbcs_clock_select_tb
  import pbcs_pkg::*;
;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        bus_clock_input, gen_clock, feedback_clock_in;
  logic        gen_enable, auto_detect_en;
  pbcs_strap_t straps;
  logic [6:0]  bus_clock_out;
  pbcs_freq_t  freq_sel;
  logic        ref_clock_pos, ref_clock_neg;
  int          mismatches, checks_done, ref_edges;

  pbcs_clock_select DUT (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .bus_clock_input(bus_clock_input), .gen_clock(gen_clock),
    .feedback_clock_in(feedback_clock_in), .strap_pins(straps),
    .bus_clock_out(bus_clock_out), .gen_enable(gen_enable),
    .auto_detect_en(auto_detect_en), .freq_sel(freq_sel)
  );
  pbcs_board_model board (.gen_clock(gen_clock), .feedback_clock_in(feedback_clock_in),
    .ref_clock_pos(ref_clock_pos), .ref_clock_neg(ref_clock_neg));
  always @(posedge ref_clock_pos) ref_edges++;

  always #20 clk = ~clk;

  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  // one apb transfer; the wait on pready is cut short only by the watchdog
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pin parked at a static level through reset; leaving reset counts no rise
  task do_reset(input logic lvl);
    @(posedge clk);
    bus_clock_input <= lvl;
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(ref_edges > 0, 1'b1)
    `CHK(ref_clock_pos ^ ref_clock_neg, 1'b1)
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // two cycles high, two low: slow enough for the 2ff sampler
  task pulse(input int n);
    repeat (n) begin
      @(posedge clk) bus_clock_input <= 1'b1;
      repeat (2) @(posedge clk);
      bus_clock_input <= 1'b0;
      @(posedge clk);
    end
  endtask : pulse

  task chk_freq(input logic p, input logic [1:0] c, input logic s, input logic r,
                input pbcs_freq_t f, input logic [7:0] m);
    @(posedge clk);
    bus_clock_input <= p;
    straps <= '{reverse: r, sel_up: s, cap: c};
    repeat (5) @(posedge clk);
    `CHK(freq_sel, f)
    apb(1'b0, PBCS_FREQ_OFS, 32'h0);
    `CHK(rdata[7:0], m)
  endtask : chk_freq

  // or of many samples: a disabled output must never show a high level
  task outs(input logic [6:0] exp);
    logic [6:0] m;
    m = 7'h00;
    repeat (300) begin
      #7;
      m = m | bus_clock_out;
    end
    `CHK(m, exp)
  endtask : outs

  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end

  initial begin
    clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    bus_clock_input = 0; straps = '0; mismatches = 0; checks_done = 0;
    do_reset(1'b0);
    apb(1'b0, PBCS_CTRL_OFS, 32'h0);
    `CHK(rdata, {25'h0, PBCS_CLK_EN_RST})
    `CHK(gen_enable, 1'b1)
    `CHK(auto_detect_en, 1'b1)
    // pin-independent entries first with the pin low, then one rise only
    chk_freq(1'b0, PBCS_CAP_RES, 1'b1, 1'b0, PBCS_F_X50, PBCS_MHZ_50);
    chk_freq(1'b0, PBCS_CAP_RES, 1'b0, 1'b0, PBCS_F_X66, PBCS_MHZ_66);
    chk_freq(1'b0, PBCS_CAP_HIGH, 1'b1, 1'b0, PBCS_F_X100, PBCS_MHZ_100);
    chk_freq(1'b0, PBCS_CAP_HIGH, 1'b0, 1'b0, PBCS_F_X133, PBCS_MHZ_133);
    chk_freq(1'b0, PBCS_CAP_HIGH, 1'b0, 1'b1, PBCS_F_X66, PBCS_MHZ_66);
    chk_freq(1'b0, PBCS_CAP_GND, 1'b1, 1'b0, PBCS_F_PCI25, PBCS_MHZ_25);
    chk_freq(1'b0, PBCS_CAP_GND, 1'b0, 1'b0, PBCS_F_PCI33, PBCS_MHZ_33);
    chk_freq(1'b1, PBCS_CAP_GND, 1'b1, 1'b0, PBCS_F_PCI50, PBCS_MHZ_50);
    chk_freq(1'b1, PBCS_CAP_GND, 1'b0, 1'b0, PBCS_F_PCI66, PBCS_MHZ_66);
    apb(1'b0, PBCS_STATUS_OFS, 32'h0);
    `CHK(rdata[PBCS_ST_CNT_LSB +: 4], 4'h1)
    `CHK(rdata[PBCS_ST_EXT_BIT], 1'b0)
    `CHK(rdata[PBCS_ST_FB_BIT], 1'b1)
    // output enables, then all outputs back on
    apb(1'b1, PBCS_CTRL_OFS, 32'h5);
    apb(1'b0, PBCS_CTRL_OFS, 32'h0);
    `CHK(rdata, 32'h5)
    repeat (8) @(posedge clk);
    outs(7'h05);
    apb(1'b1, PBCS_CTRL_OFS, 32'h7f);
    repeat (8) @(posedge clk);
    outs(7'h7f);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rdata, 32'h0)
    // fourteen rises stay internal, the fifteenth forces external mode
    do_reset(1'b0);
    pulse(14);
    repeat (6) @(posedge clk);
    apb(1'b0, PBCS_STATUS_OFS, 32'h0);
    `CHK(rdata[PBCS_ST_EXT_BIT], 1'b0)
    `CHK(rdata[PBCS_ST_CNT_LSB +: 4], 4'he)
    `CHK(gen_enable, 1'b1)
    pulse(1);
    repeat (6) @(posedge clk);
    `CHK(gen_enable, 1'b0)
    `CHK(auto_detect_en, 1'b0)
    pulse(2);
    bus_clock_input <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, PBCS_STATUS_OFS, 32'h0);
    `CHK(rdata[PBCS_ST_EXT_BIT], 1'b1)
    `CHK(rdata[PBCS_ST_CNT_LSB +: 4], PBCS_EDGE_LIMIT)
    // external mode: outputs follow the pin, not the running generator
    outs(7'h7f);
    @(posedge clk);
    bus_clock_input <= 1'b0;
    repeat (8) @(posedge clk);
    outs(7'h00);
    // pin strapped high through reset: no false rise, internal mode again
    do_reset(1'b1);
    apb(1'b0, PBCS_STATUS_OFS, 32'h0);
    `CHK(rdata[PBCS_ST_EXT_BIT], 1'b0)
    `CHK(rdata[PBCS_ST_CNT_LSB +: 4], 4'h0)
    `CHK(gen_enable, 1'b1)
    complete_run();
  end
endmodule : pbcs_clock_select_tb
`default_nettype wire
